/* File: core/sample_buffer.sv */
// Two-entry valid/ready buffer between measurement source and link
`timescale 1ns/1ps
module sample_buffer
   import sensor_link_pkg::*;
#(
   parameter int unsigned WIDTH = 32
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic [WIDTH-1:0]      o_out_data
);

   typedef struct packed {
      logic [1:0][WIDTH-1:0] mem;
      logic                  rd;
      logic                  wr;
      logic [1:0]            cnt;
   } buf_state_t;

   buf_state_t st_ff;
   buf_state_t nxt_st;
   logic       push;
   logic       pop;

   assign o_in_ready  = (st_ff.cnt != 2'h2);
   assign o_out_valid = (st_ff.cnt != 2'h0);
   assign o_out_data  = st_ff.mem[st_ff.rd];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   always_comb begin
      nxt_st = st_ff;
      if (push) begin
         nxt_st.mem[st_ff.wr] = i_in_data;
         nxt_st.wr            = ~st_ff.wr;
      end
      if (pop) begin
         nxt_st.rd = ~st_ff.rd;
      end
      case ({push, pop})
         2'b10:   nxt_st.cnt = st_ff.cnt + 2'h1;
         2'b01:   nxt_st.cnt = st_ff.cnt - 2'h1;
         default: nxt_st.cnt = st_ff.cnt;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

endmodule

/* File: core/sensor_link.sv */
// Sensor-side single-wire readout link: pin timing, framing, sampling
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module sensor_link
   import sensor_link_pkg::*;
#(
   parameter int unsigned POWERUP_CYCLES = POWERUP_CYC,
   parameter int unsigned START_CYCLES   = START_MIN_CYC,
   parameter int unsigned MEAS_CYCLES    = MEAS_CYC,
   parameter int unsigned CYC_PER_US     = CLK_MHZ
) (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_sda,
   output logic             o_sda,
   output logic             o_sda_oe_n,
   input  wire logic [15:0] i_hum,
   input  wire logic [15:0] i_temp,
   output logic             o_measure,
   output logic             o_busy
);

   ////////////////////////////////////////////////////////////////////////
   // Phase lengths in clocks; the clock rate is a parameter so a bench
   // can run whole frames in some 13000 to 20000 cycles

   localparam int unsigned TURN_CYCLES      = TURN_US * CYC_PER_US;
   localparam int unsigned RESP_LOW_CYCLES  = RESP_LOW_US * CYC_PER_US;
   localparam int unsigned RESP_HIGH_CYCLES = RESP_HIGH_US * CYC_PER_US;
   localparam int unsigned BIT_LOW_CYCLES   = BIT_LOW_US * CYC_PER_US;
   localparam int unsigned BIT0_HIGH_CYCLES = BIT0_HIGH_US * CYC_PER_US;
   localparam int unsigned BIT1_HIGH_CYCLES = BIT1_HIGH_US * CYC_PER_US;
   localparam int unsigned END_LOW_CYCLES   = END_LOW_US * CYC_PER_US;

   ////////////////////////////////////////////////////////////////////////
   // State record

   typedef struct packed {
      link_state_t  state;
      logic [TMR_W-1:0] tmr;
      logic [5:0]   bit_idx;
      logic [39:0]  shift;
      logic         drive_low;
      logic         meas;
      logic         push;
      logic [31:0]  stage;
      logic         sync1;
      logic         sync2;
   } link_reg_t;

   link_reg_t st_ff;
   link_reg_t nxt_st;

   sample_t   buf_out;
   logic      buf_valid;
   logic      buf_in_ready;
   logic      buf_pop;
   logic      line_hi;
   logic [7:0] csum;

   ////////////////////////////////////////////////////////////////////////
   // Sample store

   // Two slots so a sample taken while a frame is still framed never
   // overwrites the one being sent
   sample_buffer #(
      .WIDTH (32)
   ) u_buf (
      .i_clk       (i_clk),
      .i_rst_n     (i_rst_n),
      .i_in_valid  (st_ff.push),
      .o_in_ready  (buf_in_ready),
      .i_in_data   (st_ff.stage),
      .o_out_valid (buf_valid),
      .i_out_ready (buf_pop),
      .o_out_data  (buf_out)
   );

   assign line_hi = st_ff.sync2;
   // Checksum over the stored sample
   assign csum = buf_out.hum[15:8] + buf_out.hum[7:0]
               + buf_out.temp[15:8] + buf_out.temp[7:0];

   // Pop happens when the frame leaves its stored sample behind
   assign buf_pop = (st_ff.state == ST_RESP_LOW) && (st_ff.tmr == '0)
                    && buf_valid;

   assign o_sda      = 1'b0;
   assign o_sda_oe_n = ~st_ff.drive_low;
   assign o_measure  = st_ff.meas;
   assign o_busy     = (st_ff.state != ST_SLEEP);

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      nxt_st       = st_ff;
      nxt_st.sync1 = i_sda;
      nxt_st.sync2 = st_ff.sync1;
      nxt_st.push  = 1'b0;
      nxt_st.meas  = 1'b0;
      case (st_ff.state)
         ST_POWERUP: begin
            // Pin ignored until settled
            nxt_st.drive_low = 1'b0;
            if (st_ff.tmr >= TMR_W'(POWERUP_CYCLES - 1)) begin
               nxt_st.tmr   = '0;
               nxt_st.state = ST_MEASURE;
               nxt_st.meas  = 1'b1;
            end else begin
               nxt_st.tmr = st_ff.tmr + 1'b1;
            end
         end
         ST_MEASURE: begin
            // Store fresh sample for the next frame
            if (st_ff.tmr >= TMR_W'(MEAS_CYCLES - 1)) begin
               if (buf_in_ready) begin
                  nxt_st.stage = {i_hum, i_temp};
                  nxt_st.push  = 1'b1;
               end
               nxt_st.tmr   = '0;
               nxt_st.state = ST_SLEEP;
            end else begin
               nxt_st.tmr = st_ff.tmr + 1'b1;
            end
         end
         ST_SLEEP: begin
            nxt_st.drive_low = 1'b0;
            nxt_st.tmr       = '0;
            if (!line_hi) begin
               nxt_st.state = ST_START_LOW;
            end
         end
         ST_START_LOW: begin
            // Short glitches fall back to sleep
            if (line_hi) begin
               nxt_st.tmr   = '0;
               nxt_st.state = (st_ff.tmr >= TMR_W'(START_CYCLES))
                              ? ST_TURN : ST_SLEEP;
            end else if (st_ff.tmr != '1) begin
               nxt_st.tmr = st_ff.tmr + 1'b1;
            end
         end
         ST_TURN: begin
            // Fixed wait inside the host release window
            if (st_ff.tmr >= TMR_W'(TURN_CYCLES - 1)) begin
               nxt_st.tmr       = '0;
               nxt_st.drive_low = 1'b1;
               nxt_st.state     = ST_RESP_LOW;
               nxt_st.shift     = {buf_out.hum, buf_out.temp, csum};
            end else begin
               nxt_st.tmr = st_ff.tmr + 1'b1;
            end
         end
         ST_RESP_LOW: begin
            nxt_st.drive_low = 1'b1;
            if (st_ff.tmr >= TMR_W'(RESP_LOW_CYCLES - 1)) begin
               nxt_st.tmr       = '0;
               nxt_st.drive_low = 1'b0;
               nxt_st.state     = ST_RESP_HIGH;
            end else begin
               nxt_st.tmr = st_ff.tmr + 1'b1;
            end
         end
         ST_RESP_HIGH: begin
            if (st_ff.tmr >= TMR_W'(RESP_HIGH_CYCLES - 1)) begin
               nxt_st.tmr       = '0;
               nxt_st.bit_idx   = '0;
               nxt_st.drive_low = 1'b1;
               nxt_st.state     = ST_BIT_LOW;
            end else begin
               nxt_st.tmr = st_ff.tmr + 1'b1;
            end
         end
         ST_BIT_LOW: begin
            if (st_ff.tmr >= TMR_W'(BIT_LOW_CYCLES - 1)) begin
               nxt_st.tmr       = '0;
               nxt_st.drive_low = 1'b0;
               nxt_st.state     = ST_BIT_HIGH;
            end else begin
               nxt_st.tmr = st_ff.tmr + 1'b1;
            end
         end
         ST_BIT_HIGH: begin
            // MSB first: top of shift register is the current bit
            if (st_ff.tmr >= (st_ff.shift[39]
                  ? TMR_W'(BIT1_HIGH_CYCLES - 1)
                  : TMR_W'(BIT0_HIGH_CYCLES - 1))) begin
               nxt_st.tmr       = '0;
               nxt_st.shift     = {st_ff.shift[38:0], 1'b0};
               nxt_st.bit_idx   = st_ff.bit_idx + 6'h01;
               nxt_st.drive_low = 1'b1;
               nxt_st.state = (st_ff.bit_idx == 6'(FRAME_BITS - 1))
                              ? ST_END_LOW : ST_BIT_LOW;
            end else begin
               nxt_st.tmr = st_ff.tmr + 1'b1;
            end
         end
         ST_END_LOW: begin
            if (st_ff.tmr >= TMR_W'(END_LOW_CYCLES - 1)) begin
               nxt_st.tmr       = '0;
               nxt_st.drive_low = 1'b0;
               nxt_st.meas      = 1'b1;
               nxt_st.state     = ST_MEASURE;
            end else begin
               nxt_st.tmr = st_ff.tmr + 1'b1;
            end
         end
         default: begin
            nxt_st = '0;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_ff       <= '0;
         st_ff.sync1 <= 1'b1;
         st_ff.sync2 <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

endmodule

/* File: core/sensor_link_pkg.sv */
// Shared constants and types for the single-wire sensor readout link
package sensor_link_pkg;

   localparam int unsigned CLK_MHZ        = 200;
   localparam int unsigned START_MIN_US   = 800;
   localparam int unsigned RESP_LOW_US    = 80;
   localparam int unsigned RESP_HIGH_US   = 80;
   localparam int unsigned BIT_LOW_US     = 50;
   localparam int unsigned BIT0_HIGH_US   = 26;
   localparam int unsigned BIT1_HIGH_US   = 70;
   localparam int unsigned END_LOW_US     = 50;
   localparam int unsigned TURN_US        = 30;
   localparam int unsigned POWERUP_MS     = 2000;
   localparam int unsigned MEAS_US        = 1000;

   localparam int unsigned START_MIN_CYC  = START_MIN_US * CLK_MHZ;
   localparam int unsigned RESP_LOW_CYC   = RESP_LOW_US * CLK_MHZ;
   localparam int unsigned RESP_HIGH_CYC  = RESP_HIGH_US * CLK_MHZ;
   localparam int unsigned BIT_LOW_CYC    = BIT_LOW_US * CLK_MHZ;
   localparam int unsigned BIT0_HIGH_CYC  = BIT0_HIGH_US * CLK_MHZ;
   localparam int unsigned BIT1_HIGH_CYC  = BIT1_HIGH_US * CLK_MHZ;
   localparam int unsigned END_LOW_CYC    = END_LOW_US * CLK_MHZ;
   localparam int unsigned TURN_CYC       = TURN_US * CLK_MHZ;
   localparam int unsigned POWERUP_CYC    = POWERUP_MS * 1000 * CLK_MHZ;
   localparam int unsigned MEAS_CYC       = MEAS_US * CLK_MHZ;

   localparam int unsigned FRAME_BITS     = 40;
   localparam int unsigned TMR_W          = 32;
   localparam logic [31:0] HUM_RST        = 32'h0000_0000;

   typedef struct packed {
      logic [15:0] hum;
      logic [15:0] temp;
   } sample_t;

   typedef enum logic [3:0] {
      ST_POWERUP,
      ST_MEASURE,
      ST_SLEEP,
      ST_START_LOW,
      ST_TURN,
      ST_RESP_LOW,
      ST_RESP_HIGH,
      ST_BIT_LOW,
      ST_BIT_HIGH,
      ST_END_LOW
   } link_state_t;

endpackage

/* File: test/host_model.sv */
// Host model: start pulse, release, bit decoding by high time
`timescale 1ns/1ps
module host_model
   import sensor_link_pkg::*;
#(
   parameter int unsigned CYC_PER_US = CLK_MHZ
) (
   input  wire logic i_clk,
   input  wire logic i_line,
   output logic      o_pull
);
   localparam int unsigned LIMIT = 40000;
   localparam int unsigned THRESH =
      (BIT0_HIGH_US + BIT1_HIGH_US) * CYC_PER_US / 2;
   initial o_pull = 1'b0;
   task automatic send_start(input int unsigned n);
      @(negedge i_clk);
      o_pull = 1'b1;
      repeat (n) @(negedge i_clk);
      o_pull = 1'b0;
   endtask
   // Bounded, and skipped once failed, so a dead sensor ends quickly
   task automatic wait_lvl(input logic lvl, output int unsigned n,
                           inout logic ok);
      n = 0;
      while (ok && i_line !== lvl && n < LIMIT) begin
         @(negedge i_clk);
         n++;
      end
      if (n >= LIMIT) ok = 1'b0;
   endtask
   task automatic read_frame(output logic [39:0] bits,
      output int unsigned t_go, output int unsigned t_lo,
      output int unsigned t_hi, output logic ok);
      int unsigned n;
      ok = 1'b1;
      // Line still reads the host's own low until the release settles
      wait_lvl(1'b1, n, ok);
      wait_lvl(1'b0, t_go, ok);
      wait_lvl(1'b1, t_lo, ok);
      wait_lvl(1'b0, t_hi, ok);
      for (int i = 39; i >= 0; i--) begin
         wait_lvl(1'b1, n, ok);
         wait_lvl(1'b0, n, ok);
         bits[i] = (n > THRESH);
      end
      wait_lvl(1'b1, n, ok);
   endtask
endmodule

/* File: test/sensor_link_props.sv */
// Timing checker for the sensor-side single-wire link
`timescale 1ns/1ps
module sensor_link_props
   import sensor_link_pkg::*;
#(
   parameter int unsigned CYC_PER_US = CLK_MHZ
) (
   input logic        i_clk,
   input logic        i_rst_n,
   input logic        i_sda,
   input logic        o_sda,
   input logic        o_sda_oe_n,
   input logic [15:0] i_hum,
   input logic [15:0] i_temp,
   input logic        o_measure,
   input logic        o_busy
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   localparam int unsigned RESP_LO = RESP_LOW_US * CYC_PER_US;
   localparam int unsigned RESP_HI = RESP_HIGH_US * CYC_PER_US;
   localparam int unsigned BIT_LO  = BIT_LOW_US * CYC_PER_US;
   localparam int unsigned BIT0_HI = BIT0_HIGH_US * CYC_PER_US;
   localparam int unsigned BIT1_HI = BIT1_HIGH_US * CYC_PER_US;
   localparam int unsigned END_LO  = END_LOW_US * CYC_PER_US;
   logic [31:0] lo_ff;
   logic [31:0] hi_ff;
   logic [5:0]  nfall_ff;
   logic        prev_ff;
   ////////////////////////////////////////
   // Run lengths; fall count tells response, bits and end apart
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lo_ff    <= 32'h0;
         hi_ff    <= 32'h0;
         nfall_ff <= 6'h00;
         prev_ff  <= 1'b1;
      end else begin
         lo_ff    <= o_sda_oe_n ? 32'h0 : lo_ff + 32'h1;
         hi_ff    <= o_sda_oe_n ? hi_ff + 32'h1 : 32'h0;
         nfall_ff <= !o_busy ? 6'h00
                   : nfall_ff + {5'h00, prev_ff & !o_sda_oe_n};
         prev_ff  <= o_sda_oe_n;
      end
   end
   ////////////////////////////////////////
   property p_sda_zero;
      o_sda == 1'b0;
   endproperty
   a_sda_zero: assert property (p_sda_zero)
      else $error("open drain data not low");
   property p_idle;
      !o_busy |-> o_sda_oe_n;
   endproperty
   a_idle: assert property (p_idle)
      else $error("line driven while asleep");
   property p_low_len;
      $rose(o_sda_oe_n) |->
         lo_ff == (nfall_ff == 6'h01 ? RESP_LO
                   : (nfall_ff == 6'h2A ? END_LO : BIT_LO));
   endproperty
   a_low_len: assert property (p_low_len)
      else $error("wrong low length");
   property p_high_len;
      $fell(o_sda_oe_n) && nfall_ff != 6'h00 |->
         (nfall_ff == 6'h01 ? hi_ff == RESP_HI
          : hi_ff inside {BIT0_HI, BIT1_HI});
   endproperty
   a_high_len: assert property (p_high_len)
      else $error("wrong high length");
   property p_turn;
      $fell(o_sda_oe_n) && nfall_ff == 6'h00 |->
         $past(i_sda) && $past(i_sda, 8);
   endproperty
   a_turn: assert property (p_turn)
      else $error("response before host release");
   property p_fall_limit;
      $fell(o_sda_oe_n) |-> nfall_ff < 6'h2A;
   endproperty
   a_fall_limit: assert property (p_fall_limit)
      else $error("too many low pulses in frame");
   property p_end_measure;
      $rose(o_sda_oe_n) && nfall_ff == 6'h2A |-> o_measure;
   endproperty
   a_end_measure: assert property (p_end_measure)
      else $error("no measurement after frame");
   property p_measure_when;
      o_measure |-> o_sda_oe_n && (nfall_ff == 6'h00 || nfall_ff == 6'h2A);
   endproperty
   a_measure_when: assert property (p_measure_when)
      else $error("measurement inside a frame");
endmodule
bind sensor_link sensor_link_props #(.CYC_PER_US(CYC_PER_US)) i_props (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sda(i_sda), .o_sda(o_sda),
   .o_sda_oe_n(o_sda_oe_n), .i_hum(i_hum), .i_temp(i_temp),
   .o_measure(o_measure), .o_busy(o_busy));

/* File: test/sensor_link_test.sv */
// Self-checking bench for the sensor-side single-wire link
`timescale 1ns/1ps
module sensor_link_test
   import sensor_link_pkg::*;
;
   localparam logic [15:0] HA = 16'h0292;
   localparam logic [15:0] TA = 16'h8065;
   localparam logic [15:0] HB = 16'h01F4;
   localparam logic [15:0] TB = 16'h00FA;
   // Clocks per microsecond in the bench, to keep frames short
   localparam int unsigned SC = 4;
   logic        i_clk;
   logic        i_rst_n;
   logic        line;
   logic        host_pull;
   logic        o_sda;
   logic        o_sda_oe_n;
   logic        o_measure;
   logic        o_busy;
   logic [15:0] i_hum;
   logic [15:0] i_temp;
   int unsigned n_fail;
   int unsigned total_checks;
   // Pull-up wins unless someone pulls low
   assign line = host_pull ? 1'b0 : (o_sda_oe_n ? 1'b1 : o_sda);
   sensor_link #(.POWERUP_CYCLES(100), .START_CYCLES(50),
      .MEAS_CYCLES(20), .CYC_PER_US(SC)) i_sensor_link (.i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_sda(line), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .i_hum(i_hum),
      .i_temp(i_temp), .o_measure(o_measure), .o_busy(o_busy));
   host_model #(.CYC_PER_US(SC)) i_host_model (.i_clk(i_clk), .i_line(line),
      .o_pull(host_pull));
   ////////////////////////////////////////
   task automatic chk(input logic bad, input string msg);
      total_checks++;
      if (bad !== 1'b0) begin
         n_fail++;
         $display("MISMATCH at %0t: %s", $time, msg);
      end
   endtask
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic wait_idle();
      int unsigned n;
      n = 0;
      while (o_busy !== 1'b0 && n < 1000) begin
         @(negedge i_clk);
         n++;
      end
      if (n >= 1000) begin
         chk(1'b1, "sensor never went to sleep");
         report_and_stop();
      end
   endtask
   ////////////////////////////////////////
   task automatic t_ignored(input int unsigned n, input string name);
      logic seen;
      seen = 1'b0;
      i_host_model.send_start(n);
      repeat (7000) begin
         @(negedge i_clk);
         if (o_sda_oe_n !== 1'b1) seen = 1'b1;
      end
      chk(seen, "sensor answered an ignored start");
      $display("Test %s done", name);
   endtask
   task automatic t_frame(input logic [15:0] eh, input logic [15:0] et,
      input logic [15:0] nh, input logic [15:0] nt, input string name);
      logic [39:0] bits;
      logic [7:0]  sum;
      logic [7:0]  rx_sum;
      int unsigned t_go;
      int unsigned t_lo;
      int unsigned t_hi;
      logic        ok;
      logic        seen;
      sum = eh[15:8] + eh[7:0] + et[15:8] + et[7:0];
      seen = 1'b0;
      // New inputs now must not reach this frame
      i_hum = nh;
      i_temp = nt;
      i_host_model.send_start(60);
      i_host_model.read_frame(bits, t_go, t_lo, t_hi, ok);
      if (!ok) begin
         chk(1'b1, "frame timed out");
         report_and_stop();
      end
      rx_sum = bits[39:32] + bits[31:24] + bits[23:16] + bits[15:8];
      chk(bits !== {eh, et, sum}, "frame bits");
      chk(bits[7:0] !== rx_sum, "checksum");
      chk(t_go < 10 * SC || t_go > 200 * SC, "release time");
      chk(t_lo < 75 * SC || t_lo > 85 * SC, "response low");
      chk(t_hi < 75 * SC || t_hi > 85 * SC, "response high");
      // Pulse rises with the release, already up when the host sees it
      if (o_measure === 1'b1) seen = 1'b1;
      repeat (4) begin
         @(negedge i_clk);
         if (o_measure === 1'b1) seen = 1'b1;
      end
      chk(!seen, "no measurement after frame");
      wait_idle();
      chk(line !== 1'b1, "line not released");
      $display("Test %s done", name);
   endtask
   ////////////////////////////////////////
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   initial begin
      n_fail = 0;
      total_checks = 0;
      i_rst_n = 1'b0;
      i_hum = HA;
      i_temp = TA;
      repeat (2) @(negedge i_clk);
      i_rst_n = 1'b1;
      t_ignored(60, "powerup");
      wait_idle();
      t_ignored(20, "short");
      t_frame(HA, TA, HB, TB, "first");
      // Spacing between reads shortened; the sensor enforces none
      wait_idle();
      t_frame(HB, TB, HA, TA, "second");
      report_and_stop();
   end
endmodule
